// ---- src/iaf_flags.sv ----
// arbitration lost, own address match and general call flags with apb
// assumes scl/sda pins arrive raw; internal sda/scl come from clk_sys logic
//
// Our own choices: the placing of the registers and the APB register port.
`timescale 1ns/1ns
`default_nettype none
`include "iaf_regs.svh"

module iaf_flags
   import iaf_pkg::*;
  (
   // clock and reset
   input  wire logic         clk_sys,
   input  wire logic         rst_n,
   // apb slave
   input  wire iaf_apb_req_t apbReq,
   output iaf_apb_rsp_t      apbRsp,
   // bus pins, asynchronous
   input  wire logic         sclPin,
   input  wire logic         sdaPin,
   // internal line values from the transfer logic
   input  wire logic         intSda,
   input  wire logic         intScl,
   // status out
   output iaf_flags_t        flagsOut,
   output logic              irq
   );

   iaf_state_t st_reg;
   iaf_state_t st_next;

   logic [1:0] pinLvl;
   logic [1:0] pinRise;
   logic [1:0] pinFall;

   logic       sclLvl;
   logic       sdaLvl;
   logic       sclRise;
   logic       sclFall;
   logic       sdaRise;
   logic       sdaFall;

   iaf_pin_sync #(.WIDTH(2)) u_sync
     (
      .clk_sys (clk_sys),
      .rst_n   (rst_n),
      .pinIn   ({sdaPin, sclPin}),
      .pinLvl  (pinLvl),
      .pinRise (pinRise),
      .pinFall (pinFall)
      );

   assign sclLvl  = pinLvl[0];
   assign sdaLvl  = pinLvl[1];
   assign sclRise = pinRise[0];
   assign sclFall = pinFall[0];
   assign sdaRise = pinRise[1];
   assign sdaFall = pinFall[1];

   // bus decode
   logic       setupPh;
   logic       accessPh;
   logic       wrAcc;
   logic       rdAcc;
   logic       hit;
   logic [7:0] addr;
   // one select per register that the flag paths care about
   logic       selCtrl;
   logic       selFlags;
   logic       selIntStat;
   logic       selData;
   logic       wrFlags;
   logic       rdFlags;

   assign setupPh  = apbReq.psel & ~apbReq.penable;
   assign accessPh = apbReq.psel & apbReq.penable;
   assign wrAcc    = accessPh & apbReq.pwrite;
   assign rdAcc    = accessPh & ~apbReq.pwrite;
   assign addr     = apbReq.paddr;
   assign selCtrl    = (addr == `IAF_OFS_CTRL);
   assign selFlags   = (addr == `IAF_OFS_FLAGS);
   assign selIntStat = (addr == `IAF_OFS_INTSTAT);
   assign selData    = (addr == `IAF_OFS_DATA);
   assign wrFlags    = wrAcc & selFlags;
   assign rdFlags    = rdAcc & selFlags;

   always_comb
   begin
      unique case (addr)
         `IAF_OFS_CTRL,
         `IAF_OFS_ADDR,
         `IAF_OFS_FLAGS,
         `IAF_OFS_INTSTAT,
         `IAF_OFS_INTMASK,
         `IAF_OFS_DATA,
         `IAF_OFS_BUSSTAT:
            hit = 1'b1;
         default:
            hit = 1'b0;
      endcase
   end

   // event terms
   logic       masterTx;
   logic       slaveRx;
   logic       startPulse;
   logic       startCond;
   logic       stopCond;
   logic       frameDone;
   logic [7:0] frame;
   logic       genCall;
   logic       addrMatch;
   iaf_flags_t setEv;
   iaf_flags_t clrEv;
   iaf_flags_t intClr;

   assign masterTx = st_reg.ctrl.masterMode & st_reg.ctrl.transmitMode;
   assign slaveRx  = ~st_reg.ctrl.masterMode & ~st_reg.ctrl.transmitMode;

   assign startPulse = wrAcc & selCtrl & apbReq.pwdata[`IAF_CTRL_START];
   assign startCond  = sclLvl & sdaFall;
   assign stopCond   = sclLvl & sdaRise;

   assign frameDone = (st_reg.phase == PH_ADDR) & sclRise
                      & (st_reg.bitCnt == `IAF_LAST_BIT);
   assign frame     = {st_reg.shift[6:0], sdaLvl};
   // the direction bit is part of the general call compare
   assign genCall   = (frame == `IAF_GEN_CALL);
   assign addrMatch = (frame[7:1] == st_reg.primaryAddressBits);

   always_comb
   begin
      setEv = '0;

      if (masterTx)
      begin
         if (sclRise & (intSda != sdaLvl))
            setEv.arbLostFlag = 1'b1;
         if (~st_reg.ctrl.arbitrationConditionSelect & sclFall & intScl)
            setEv.arbLostFlag = 1'b1;
         // armed until this end pulls sda low itself
         if (st_reg.ctrl.arbitrationConditionSelect & st_reg.armed
             & ~sdaLvl & intSda)
            setEv.arbLostFlag = 1'b1;
      end

      if (slaveRx & frameDone)
      begin
         if (~st_reg.ctrl.primaryFormatSelect & (addrMatch | genCall))
            setEv.ownAddressMatchFlag = 1'b1;
         if (genCall & (~st_reg.ctrl.primaryFormatSelect
                        | ~st_reg.ctrl.secondaryFormatSelect))
            setEv.generalCallFlag = 1'b1;
      end
   end

   always_comb
   begin
      clrEv  = '0;
      intClr = '0;

      if (wrFlags)
         clrEv = iaf_flags_t'(~apbReq.pwdata[2:0]) & st_reg.seen;

      // data access in the current direction clears all three
      if (selData)
      begin
         if (wrAcc & st_reg.ctrl.transmitMode)
            clrEv = '1;
         if (rdAcc & ~st_reg.ctrl.transmitMode)
            clrEv = '1;
      end

      if (wrAcc & selIntStat)
         intClr = iaf_flags_t'(apbReq.pwdata[2:0]);
   end

   // per-flag next values; a set in the clear's own cycle wins so
   // that an event never vanishes under a late software clear
   logic [2:0] flagNext;
   logic [2:0] seenNext;
   logic [2:0] statNext;

   genvar b;
   generate
      for (b = 0; b < $bits(iaf_flags_t); b++)
      begin : g_flag
         assign flagNext[b] = (st_reg.flags[b] & ~clrEv[b])
                              | setEv[b];
         // seen keeps what software got back, not the live flag
         assign seenNext[b] = (rdFlags ? st_reg.prdata[b]
                                       : st_reg.seen[b])
                              & ~clrEv[b];
         assign statNext[b] = (st_reg.intStat[b] & ~intClr[b])
                              | setEv[b];
      end
   endgenerate

   // watch for an early low after a start instruction
   logic       startTx;
   logic       armNext;

   assign startTx = startPulse & apbReq.pwdata[`IAF_CTRL_MASTER]
                    & apbReq.pwdata[`IAF_CTRL_TRANSMIT];

   // disarmed once this end pulls sda itself or leaves master transmit
   always_comb
   begin
      if (startTx)
         armNext = 1'b1;
      else if (~masterTx | ~intSda | setEv.arbLostFlag)
         armNext = 1'b0;
      else
         armNext = st_reg.armed;
   end

   // read-only view of the line watch; bits above 9 read zero
   logic [31:0] busStat;

   assign busStat = {22'h0, st_reg.armed, st_reg.phase, st_reg.bitCnt,
                     sdaLvl, sclLvl};

   // next state
   always_comb
   begin
      st_next = st_reg;

      st_next.flags   = iaf_flags_t'(flagNext);
      st_next.seen    = iaf_flags_t'(seenNext);
      st_next.intStat = iaf_flags_t'(statNext);
      st_next.armed   = armNext;

      if (wrAcc)
      begin
         unique case (addr)
            `IAF_OFS_CTRL:
               st_next.ctrl = iaf_ctrl_t'(apbReq.pwdata[4:0]);
            `IAF_OFS_ADDR:
               st_next.primaryAddressBits = apbReq.pwdata[6:0];
            `IAF_OFS_INTMASK:
               st_next.intMask = iaf_flags_t'(apbReq.pwdata[2:0]);
            `IAF_OFS_DATA:
               st_next.txData = apbReq.pwdata[7:0];
            default:
               st_next.txData = st_reg.txData;
         endcase
      end

      // first frame after a start condition
      unique case (st_reg.phase)
         PH_IDLE,
         PH_DONE:
         begin
            if (startCond)
            begin
               st_next.phase  = PH_ADDR;
               st_next.bitCnt = 4'h0;
            end
         end
         PH_ADDR:
         begin
            if (stopCond)
               st_next.phase = PH_IDLE;
            else if (startCond)
               st_next.bitCnt = 4'h0;
            else if (sclRise)
            begin
               st_next.shift  = frame;
               st_next.bitCnt = st_reg.bitCnt + 4'h1;
               if (frameDone)
               begin
                  st_next.phase   = PH_DONE;
                  st_next.rxFrame = frame;
               end
            end
         end
         default:
            st_next.phase = PH_IDLE;
      endcase

      if (stopCond & (st_reg.phase == PH_DONE))
         st_next.phase = PH_IDLE;

      // read data is fetched in setup so access ends at once
      if (setupPh)
      begin
         st_next.pslverr = ~hit;
         unique case (addr)
            `IAF_OFS_CTRL:
               st_next.prdata = {27'h0, st_reg.ctrl};
            `IAF_OFS_ADDR:
               st_next.prdata = {25'h0, st_reg.primaryAddressBits};
            `IAF_OFS_FLAGS:
               st_next.prdata = {29'h0, st_reg.flags};
            `IAF_OFS_INTSTAT:
               st_next.prdata = {29'h0, st_reg.intStat};
            `IAF_OFS_INTMASK:
               st_next.prdata = {29'h0, st_reg.intMask};
            `IAF_OFS_DATA:
               st_next.prdata = st_reg.ctrl.transmitMode
                                ? {24'h0, st_reg.txData}
                                : {24'h0, st_reg.rxFrame};
            `IAF_OFS_BUSSTAT:
               st_next.prdata = busStat;
            default:
               st_next.prdata = 32'h0000_0000;
         endcase
      end
   end

   always_ff @(posedge clk_sys)
   begin
      if (!rst_n)
      begin
         st_reg       <= '0;
         st_reg.phase <= PH_IDLE;
      end
      else
      begin
         st_reg <= st_next;
      end
   end

   // outputs
   // no wait states: read data was fetched in the setup cycle, and the
   // block has no slow path that would need to stall the bus
   assign apbRsp.pready  = 1'b1;
   assign apbRsp.pslverr = st_reg.pslverr;
   assign apbRsp.prdata  = st_reg.prdata;
   assign flagsOut       = st_reg.flags;
   assign irq            = |(st_reg.intStat & st_reg.intMask);

endmodule

`default_nettype wire

// ---- src/iaf_pin_sync.sv ----
// two-stage synchroniser with edge detect for bus pin levels
// assumes pins are asynchronous to clk_sys and toggle slower than it
`timescale 1ns/1ns
`default_nettype none

module iaf_pin_sync
  #(parameter int WIDTH = 2)
  (
   // clock and reset
   input  wire logic             clk_sys,
   input  wire logic             rst_n,
   // raw pins
   input  wire logic [WIDTH-1:0] pinIn,
   // synchronised level and edges
   output logic      [WIDTH-1:0] pinLvl,
   output logic      [WIDTH-1:0] pinRise,
   output logic      [WIDTH-1:0] pinFall
   );

   typedef struct packed {
      logic [WIDTH-1:0] stage1;
      logic [WIDTH-1:0] stage2;
      logic [WIDTH-1:0] stage3;
   } iaf_sync_t;

   iaf_sync_t sync_reg;
   iaf_sync_t sync_next;

   // idle bus is high, so reset to high to avoid a false edge
   always_comb
   begin
      sync_next        = sync_reg;
      sync_next.stage1 = pinIn;
      sync_next.stage2 = sync_reg.stage1;
      sync_next.stage3 = sync_reg.stage2;
   end

   always_ff @(posedge clk_sys)
   begin
      if (!rst_n)
         sync_reg <= '1;
      else
         sync_reg <= sync_next;
   end

   // stage1 feeds stage2 only
   genvar i;
   generate
      for (i = 0; i < WIDTH; i++)
      begin : g_bit
         assign pinLvl[i]  = sync_reg.stage2[i];
         assign pinRise[i] = sync_reg.stage2[i] & ~sync_reg.stage3[i];
         assign pinFall[i] = ~sync_reg.stage2[i] & sync_reg.stage3[i];
      end
   endgenerate

endmodule

`default_nettype wire

// ---- src/iaf_pkg.sv ----
// types shared by the flag block, its port monitor and its bench
// assumes nothing beyond a systemverilog elaborator
package iaf_pkg;

   typedef struct packed {
      logic        psel;
      logic        penable;
      logic        pwrite;
      logic [7:0]  paddr;
      logic [31:0] pwdata;
   } iaf_apb_req_t;

   typedef struct packed {
      logic        pready;
      logic        pslverr;
      logic [31:0] prdata;
   } iaf_apb_rsp_t;

   // bit 0 arbitration lost, bit 1 own address, bit 2 general call
   typedef struct packed {
      logic generalCallFlag;
      logic ownAddressMatchFlag;
      logic arbLostFlag;
   } iaf_flags_t;

   typedef struct packed {
      logic secondaryFormatSelect;
      logic primaryFormatSelect;
      logic arbitrationConditionSelect;
      logic transmitMode;
      logic masterMode;
   } iaf_ctrl_t;

   typedef enum logic [2:0] {
      PH_IDLE = 3'b001,
      PH_ADDR = 3'b010,
      PH_DONE = 3'b100
   } iaf_phase_t;

   typedef struct packed {
      iaf_ctrl_t   ctrl;
      logic [6:0]  primaryAddressBits;
      iaf_flags_t  flags;
      iaf_flags_t  seen;
      iaf_flags_t  intStat;
      iaf_flags_t  intMask;
      logic [7:0]  txData;
      logic [7:0]  rxFrame;
      logic [7:0]  shift;
      logic [3:0]  bitCnt;
      iaf_phase_t  phase;
      logic        armed;
      logic [31:0] prdata;
      logic        pslverr;
   } iaf_state_t;

endpackage

// ---- src/iaf_regs.svh ----
// register offsets, field positions and reset values of the flag block
// assumes a byte-addressed apb bus with one aligned 32-bit word per register
`ifndef IAF_REGS_SVH
`define IAF_REGS_SVH

`define IAF_OFS_CTRL      8'h00
`define IAF_OFS_ADDR      8'h04
`define IAF_OFS_FLAGS     8'h08
`define IAF_OFS_INTSTAT   8'h0C
`define IAF_OFS_INTMASK   8'h10
`define IAF_OFS_DATA      8'h14
`define IAF_OFS_BUSSTAT   8'h18

`define IAF_CTRL_MASTER   0
`define IAF_CTRL_TRANSMIT 1
`define IAF_CTRL_ARBSEL   2
`define IAF_CTRL_PRIMFMT  3
`define IAF_CTRL_SECFMT   4
`define IAF_CTRL_START    5

`define IAF_FLAG_ARB      0
`define IAF_FLAG_OWN      1
`define IAF_FLAG_GEN      2

`define IAF_CTRL_RST      5'h00
`define IAF_ADDR_RST      7'h00
`define IAF_FLAGS_RST     3'h0
`define IAF_MASK_RST      3'h0

`define IAF_GEN_CALL      8'h00
`define IAF_LAST_BIT      4'h7

`endif

// ---- tb/iaf_bus_model.sv ----
// far-side bus party: its share of the wired scl and sda lines
// assumes the bench ands these shares with this end's own
`timescale 1ns/1ns
`default_nettype none
module iaf_bus_model
  (
   // wired-and shares
   output var logic scl,
   output var logic sda
   );
   // released lines sit at the pull-up level
   initial
   begin
      scl = 1'b1;
      sda = 1'b1;
   end
   // odd offset keeps line moves off the clock edge
   task automatic drive(input logic c, input logic d);
      #13 sda = d;
      scl = c;
      #400;
   endtask
   // start, eight bits msb first, stop; scl still between frames
   task automatic frame(input logic [7:0] b);
      #13 sda = 1'b0;
      #200 scl = 1'b0;
      for (int i = 7; i >= 0; i--)
      begin
         sda = b[i];
         #100 scl = 1'b1;
         #200 scl = 1'b0;
         #100;
      end
      sda = 1'b0;
      #100 scl = 1'b1;
      #100 sda = 1'b1;
      #200;
   endtask
endmodule
`default_nettype wire

// ---- tb/iaf_flags_monitor.sv ----
// port checker of the flag block, bound to its top
// assumes zero-wait apb and raw pins from one bus
`timescale 1ns/1ns
`default_nettype none
`include "iaf_regs.svh"
module iaf_flags_monitor
   import iaf_pkg::*;
  (
   // clock and reset
   input wire logic         clk_sys,
   input wire logic         rst_n,
   // apb and lines
   input wire iaf_apb_req_t apbReq,
   input wire iaf_apb_rsp_t apbRsp,
   input wire logic         sclPin,
   input wire logic         sdaPin,
   input wire logic         intSda,
   input wire logic         intScl,
   // status
   input wire iaf_flags_t   flagsOut,
   input wire logic         irq
   );
   logic [3:0] quietReg;
   logic [2:0] seenReg;
   logic [1:0] pinReg;
   wire logic  acc = apbReq.psel && apbReq.penable;
   wire logic  atFl = apbReq.paddr == `IAF_OFS_FLAGS;
   wire logic  wrFl = acc && apbReq.pwrite && atFl;
   wire logic  rdFl = acc && !apbReq.pwrite && atFl;
   wire logic  wrMk = acc && apbReq.pwrite
                      && apbReq.paddr == `IAF_OFS_INTMASK;
   wire logic  wrCt = acc && apbReq.pwrite
                      && apbReq.paddr == `IAF_OFS_CTRL;
   // flags may only rise a few cycles after the lines moved or after
   // a start instruction armed the early-low watch on a resting bus
   always_ff @(posedge clk_sys)
   begin
      pinReg <= {sclPin, sdaPin};
      if (!rst_n || pinReg != {sclPin, sdaPin} || wrCt)
         quietReg <= 4'h0;
      else if (quietReg != 4'hF)
         quietReg <= quietReg + 4'h1;
      if (!rst_n)
         seenReg <= 3'h0;
      else if (rdFl)
         seenReg <= apbRsp.prdata[2:0];
      else
         seenReg <= seenReg & flagsOut;
   end
   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (!rst_n);
   sequence zeroArb_s;
      wrFl && !apbReq.pwdata[0];
   endsequence
   reset_all_a: assert property (disable iff (1'b0)
      !rst_n |=> flagsOut == 3'h0 && !irq) else $error("set after reset");
   pready_up_a: assert property (apbRsp.pready) else $error("pready low");
   unmapped_ref_a: assert property (apbReq.psel && !apbReq.penable &&
      apbReq.paddr > `IAF_OFS_BUSSTAT |=> apbRsp.pslverr &&
      apbRsp.prdata == 32'h0) else $error("unmapped not refused");
   rsp_hold_a: assert property (acc |=> $stable(apbRsp.prdata))
      else $error("read data moved");
   quiet_set_a: assert property (
      quietReg > 4'h8 |-> (flagsOut & ~$past(flagsOut)) == 3'h0)
      else $error("flag set without bus activity");
   seen_clear_a: assert property (
      zeroArb_s ##0 seenReg[0] |=> !flagsOut.arbLostFlag)
      else $error("seen flag kept");
   unseen_keep_a: assert property (
      zeroArb_s ##0 !seenReg[0] && flagsOut.arbLostFlag |=>
      flagsOut.arbLostFlag) else $error("unseen flag cleared");
   mask_off_a: assert property (
      wrMk && apbReq.pwdata[2:0] == 3'h0 |=> !irq) else $error("irq kept");
endmodule
bind iaf_flags iaf_flags_monitor mon_u (.clk_sys, .rst_n, .apbReq,
   .apbRsp, .sclPin, .sdaPin, .intSda, .intScl, .flagsOut, .irq);
`default_nettype wire

// ---- tb/iaf_flags_tb.sv ----
// self-checking bench of the flag block with a far-side bus party
// assumes zero-wait apb; lines are the and of both shares
`timescale 1ns/1ns
`default_nettype none
`include "iaf_regs.svh"
module iaf_flags_tb
   import iaf_pkg::*;
   ();
   typedef struct packed {
      logic [7:0] ctrl;
      logic [7:0] frame;
      logic [2:0] flags;
   } iaf_row_t;
   // slave cases, primary address 2A
   iaf_row_t     rows [8] = '{
      '{8'h00, 8'h54, 3'h2}, '{8'h00, 8'h00, 3'h6},
      '{8'h08, 8'h00, 3'h4}, '{8'h18, 8'h00, 3'h0},
      '{8'h10, 8'h00, 3'h6}, '{8'h00, 8'h56, 3'h0},
      '{8'h08, 8'h54, 3'h0}, '{8'h02, 8'h54, 3'h0}};
   logic         clk_sys;
   logic         rst_n;
   iaf_apb_req_t apbReq;
   iaf_apb_rsp_t apbRsp;
   logic         intSda, intScl, mScl, mSda, irq;
   wire logic    sclPin = intScl & mScl;
   wire logic    sdaPin = intSda & mSda;
   iaf_flags_t   flagsOut;
   logic [31:0]  rdata;
   int           nFail = 0;
   int           totalChecks = 0;
   int           cyc = 0;
   iaf_flags dut_u (.clk_sys, .rst_n, .apbReq, .apbRsp, .sclPin, .sdaPin,
      .intSda, .intScl, .flagsOut, .irq);
   iaf_bus_model bus_u (.scl(mScl), .sda(mSda));
   initial
   begin
      clk_sys = 1'b0;
      forever #25 clk_sys = ~clk_sys;
   end
   // a hang counts as a mismatch
   always @(posedge clk_sys)
   begin
      cyc <= cyc + 1;
      if (cyc == 6000)
      begin
         nFail++;
         finalReport();
      end
   end
   task automatic chk(input logic [31:0] s, input logic [31:0] e);
      totalChecks++;
      if (s !== e)
      begin
         nFail++;
         $display("CHECK FAILED at %0t seen %h expected %h", $time, s, e);
      end
   endtask
   task automatic apb(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
      @(posedge clk_sys);
      apbReq <= '{1'b1, 1'b0, w, a, d};
      @(posedge clk_sys);
      apbReq.penable <= 1'b1;
      do
         @(posedge clk_sys);
      while (apbRsp.pready !== 1'b1);
      rdata = apbRsp.prdata;
      apbReq.psel <= 1'b0;
      apbReq.penable <= 1'b0;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask
   task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
      apb(1'b0, a, 32'h0);
      chk(rdata, e);
   endtask
   task automatic finalReport();
      $display("checks %0d mismatches %0d", totalChecks, nFail);
      if (nFail == 0 && totalChecks > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   initial
   begin
      rst_n = 1'b0;
      apbReq = '0;
      intSda = 1'b1;
      intScl = 1'b1;
      repeat (5) @(posedge clk_sys);
      rst_n <= 1'b1;
      for (int a = 0; a <= 16; a += 4)
         rdchk(8'(a), 32'h0);
      rdchk(8'h1C, 32'h0);
      rdchk(`IAF_OFS_BUSSTAT, 32'h43);
      wr(`IAF_OFS_INTMASK, 32'h7);
      wr(`IAF_OFS_ADDR, 32'h2A);
      foreach (rows[i])
      begin
         wr(`IAF_OFS_CTRL, {24'h0, rows[i].ctrl});
         bus_u.frame(rows[i].frame);
         chk({29'h0, flagsOut}, {29'h0, rows[i].flags});
         rdchk(`IAF_OFS_FLAGS, {29'h0, rows[i].flags});
         wr(`IAF_OFS_FLAGS, 32'h0);
         rdchk(`IAF_OFS_FLAGS, 32'h0);
      end
      chk({31'h0, irq}, 32'h1);
      rdchk(`IAF_OFS_INTSTAT, 32'h6);
      wr(`IAF_OFS_INTMASK, 32'h0);
      @(negedge clk_sys);
      chk({31'h0, irq}, 32'h0);
      wr(`IAF_OFS_INTMASK, 32'h7);
      @(negedge clk_sys);
      chk({31'h0, irq}, 32'h1);
      wr(`IAF_OFS_INTSTAT, 32'h7);
      @(negedge clk_sys);
      chk({31'h0, irq}, 32'h0);
      wr(`IAF_OFS_CTRL, 32'h0);
      bus_u.frame(8'h54);
      rdchk(`IAF_OFS_DATA, 32'h54);
      rdchk(`IAF_OFS_FLAGS, 32'h0);
      wr(`IAF_OFS_CTRL, 32'h7);
      intSda <= 1'b0;
      bus_u.drive(1'b0, 1'b0);
      bus_u.drive(1'b1, 1'b0);
      rdchk(`IAF_OFS_FLAGS, 32'h0);
      intSda <= 1'b1;
      bus_u.drive(1'b0, 1'b0);
      bus_u.drive(1'b1, 1'b0);
      wr(`IAF_OFS_FLAGS, 32'h0);
      rdchk(`IAF_OFS_FLAGS, 32'h1);
      wr(`IAF_OFS_DATA, 32'h5A);
      rdchk(`IAF_OFS_FLAGS, 32'h0);
      rdchk(`IAF_OFS_DATA, 32'h5A);
      bus_u.drive(1'b1, 1'b1);
      wr(`IAF_OFS_FLAGS, 32'h7);
      rdchk(`IAF_OFS_FLAGS, 32'h0);
      wr(`IAF_OFS_CTRL, 32'h3);
      intScl <= 1'b0;
      bus_u.drive(1'b1, 1'b1);
      @(posedge clk_sys);
      intScl <= 1'b1;
      bus_u.drive(1'b1, 1'b1);
      rdchk(`IAF_OFS_FLAGS, 32'h0);
      bus_u.drive(1'b0, 1'b1);
      bus_u.drive(1'b1, 1'b1);
      rdchk(`IAF_OFS_FLAGS, 32'h1);
      wr(`IAF_OFS_FLAGS, 32'h0);
      rdchk(`IAF_OFS_FLAGS, 32'h0);
      wr(`IAF_OFS_CTRL, 32'h27);
      bus_u.drive(1'b1, 1'b0);
      rdchk(`IAF_OFS_FLAGS, 32'h1);
      bus_u.drive(1'b1, 1'b1);
      // mid-run reset with a flag and the interrupt pending
      @(posedge clk_sys);
      rst_n <= 1'b0;
      repeat (2) @(posedge clk_sys);
      rst_n <= 1'b1;
      chk({29'h0, flagsOut}, 32'h0);
      rdchk(`IAF_OFS_FLAGS, 32'h0);
      chk({31'h0, irq}, 32'h0);
      finalReport();
   end
endmodule
`default_nettype wire
